// ==== design/sscd_baud_scan.sv ====
// Auto-detect baud scanner: steps through rates in ascending order.
// Assumes the port logic raises detect when a programming device answers.
`default_nettype none
module sscd_baud_scan
  import sscd_pkg::*;
#(
  parameter int DWELL = BAUD_DWELL_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic detect,
  output logic [1:0] baud_sel,
  output logic locked
);
  // Refuse a zero dwell at elaboration: the scanner could never leave a rate.
  if (DWELL < 1)
  begin : g_bad_dwell
    $error("DWELL must be at least one cycle");
  end
  logic [1:0] baud_q, baud_d;
  logic lock_q, lock_d;
  logic [31:0] cnt_q, cnt_d;
  // ****************************************
  // Scan step logic
  // ****************************************
  // ascending rate order
  always_comb
  begin
    baud_d = baud_q;
    lock_d = lock_q;
    cnt_d = cnt_q;
    if (!enable)
    begin
      baud_d = BAUD_9600;
      lock_d = 1'b0;
      cnt_d = '0;
    end
    else if (!lock_q)
    begin
      if (detect)
      begin
        lock_d = 1'b1;
      end
      else if (cnt_q == 32'(DWELL - 1))
      begin
        cnt_d = '0;
        baud_d = 2'(baud_q + 2'h1); // Wraps from the fastest back to 9600.
      end
      else
      begin
        cnt_d = 32'(cnt_q + 32'h1);
      end
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      baud_q <= BAUD_9600;
      lock_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      baud_q <= baud_d;
      lock_q <= lock_d;
      cnt_q <= cnt_d;
    end
  end
  assign baud_sel = baud_q;
  assign locked = lock_q;
  AST_BAUD_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    (enable && !lock_q && baud_q != $past(baud_q) && $past(enable)) |-> baud_q == 2'($past(baud_q) + 2'h1))
    else $error("baud scan skipped a rate");
endmodule : sscd_baud_scan
`default_nettype wire

// ==== design/sscd_pkg.sv ====
// Package for the start-up switch configuration decoder.
// Assumes one 50 MHz clock and a synchronous active-high reset.
`default_nettype none
package sscd_pkg;
  // ****************************************
  // Switch positions (index into the 8-bit switch word)
  // ****************************************
  localparam int SW_WIDTH = 8;
  localparam int POS_WRITE_PROTECT = 0;
  localparam int POS_AUTOLOAD = 1;
  localparam int POS_PERIPH_SETUP = 3;
  localparam int POS_SERIAL_DEFAULT = 4;
  localparam int POS_USER_FLAG = 5;
  localparam int POS_BACKUP = 6;
  // ****************************************
  // Baud rate scan codes and timing
  // ****************************************
  localparam logic [1:0] BAUD_9600 = 2'h0;
  localparam logic [1:0] BAUD_19200 = 2'h1;
  localparam logic [1:0] BAUD_38400 = 2'h2;
  localparam logic [1:0] BAUD_115200 = 2'h3;
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_DWELL_US = 20;
  localparam int BAUD_DWELL_CYC = (CLK_HZ / 1000000) * BAUD_DWELL_US;
  localparam logic [7:0] SW_RESET_VALUE = 8'h00;
  // Output word after reset: only card verify and serial stored setup read high.
  localparam logic [10:0] OUT_RESET_VALUE = 11'h0A0;
  // Start-up sequence states.
  typedef enum logic [2:0] {
    SSCD_IDLE,
    SSCD_RESTORE,
    SSCD_AUTOLOAD,
    SSCD_RUN
  } sscd_state_e;
endpackage : sscd_pkg
`default_nettype wire

// ==== design/sscd_top.sv ====
// Start-up switch configuration decoder top level.
// Assumes the switch word is steady and synchronous to ref_clk; ON reads as 1.
// Summary of operation
// - Position 1 on blocks all user program memory writes.
// - Position 2 on at start-up loads program and setup images from card.
// - Position 7 on gives backup/restore priority and skips autoload.
// - Position 4 on uses stored setup for peripheral port, off auto-detects.
// - Position 5 on uses defaults for serial port, off uses stored setup.
// - Position 6 mirrors into the user switch flag bit.
// - Position 7 on allows write or restore; off does card verify.
// - Auto-detect tries 9600, 19200, 38400, then 115200 bps.
// - After restore, stay in program mode until power cycle.
`default_nettype none
module sscd_top
  import sscd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] dip_sw,
  input wire logic card_present,
  input wire logic load_done,
  input wire logic restore_done,
  input wire logic user_program_memory_wr_req,
  input wire logic mode_change_req,
  input wire logic periph_detect,
  output logic user_program_memory_wr_en,
  output logic autoload_program_image_req,
  output logic autoload_setup_image_req,
  output logic restore_req,
  output logic card_write_allow,
  output logic card_verify_mode,
  output logic periph_use_stored_setup,
  output logic serial_use_stored_setup,
  output logic user_switch_flag_bit,
  output logic program_mode_lock,
  output logic mode_change_ok,
  output logic [1:0] periph_baud_sel,
  output logic periph_baud_locked
);
  // ****************************************
  // Switch snapshot
  // ****************************************
  logic [7:0] snap_q, snap_d;
  logic taken_q, taken_d;
  always_comb
  begin
    snap_d = snap_q;
    taken_d = 1'b1;
    if (!taken_q)
    begin
      snap_d = dip_sw; // Caught on the first clock after reset release.
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      snap_q <= SW_RESET_VALUE;
      taken_q <= 1'b0;
    end
    else
    begin
      snap_q <= snap_d;
      taken_q <= taken_d;
    end
  end
  // ****************************************
  // Start-up sequencer
  // ****************************************
  sscd_state_e st_q, st_d;
  logic lock_q, lock_d;
  always_comb
  begin
    st_d = st_q;
    lock_d = lock_q;
    case (st_q)
      SSCD_IDLE:
      begin
        if (taken_q)
        begin
          if (snap_q[POS_BACKUP] && card_present)
          begin
            st_d = SSCD_RESTORE;
          end
          else if (snap_q[POS_AUTOLOAD] && card_present)
          begin
            st_d = SSCD_AUTOLOAD;
          end
          else
          begin
            st_d = SSCD_RUN;
          end
        end
      end
      SSCD_RESTORE:
      begin
        if (restore_done)
        begin
          lock_d = 1'b1;
          st_d = SSCD_RUN;
        end
      end
      SSCD_AUTOLOAD:
      begin
        if (load_done)
        begin
          st_d = SSCD_RUN;
        end
      end
      SSCD_RUN: st_d = SSCD_RUN;
      default: st_d = SSCD_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q <= SSCD_IDLE;
      lock_q <= 1'b0; // Power-on reset is the only way out of the lock.
    end
    else
    begin
      st_q <= st_d;
      lock_q <= lock_d;
    end
  end
  // ****************************************
  // Registered outputs
  // ****************************************
  logic [10:0] out_q, out_d;
  always_comb
  begin
    out_d[0] = user_program_memory_wr_req && !snap_q[POS_WRITE_PROTECT] && taken_q;
    out_d[1] = (st_d == SSCD_AUTOLOAD);
    out_d[2] = (st_d == SSCD_AUTOLOAD);
    out_d[3] = (st_d == SSCD_RESTORE);
    out_d[4] = snap_q[POS_BACKUP];
    out_d[5] = !snap_q[POS_BACKUP];
    out_d[6] = snap_q[POS_PERIPH_SETUP];
    out_d[7] = !snap_q[POS_SERIAL_DEFAULT];
    out_d[8] = snap_q[POS_USER_FLAG];
    out_d[9] = lock_d;
    out_d[10] = mode_change_req && !lock_d;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      out_q <= OUT_RESET_VALUE;
    end
    else
    begin
      out_q <= out_d;
    end
  end
  assign user_program_memory_wr_en = out_q[0];
  assign autoload_program_image_req = out_q[1];
  assign autoload_setup_image_req = out_q[2];
  assign restore_req = out_q[3];
  assign card_write_allow = out_q[4];
  assign card_verify_mode = out_q[5];
  assign periph_use_stored_setup = out_q[6];
  assign serial_use_stored_setup = out_q[7];
  assign user_switch_flag_bit = out_q[8];
  assign program_mode_lock = out_q[9];
  assign mode_change_ok = out_q[10];
  // ****************************************
  // Auto-detect scanner
  // ****************************************
  sscd_baud_scan #(.DWELL(BAUD_DWELL_CYC)) u_scan (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(taken_q && !snap_q[POS_PERIPH_SETUP]),
    .detect(periph_detect),
    .baud_sel(periph_baud_sel),
    .locked(periph_baud_locked)
  );
  // ****************************************
  // Assertions
  // ****************************************
  AST_WP_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
    snap_q[POS_WRITE_PROTECT] |=> !user_program_memory_wr_en)
    else $error("write passed while protected");
  AST_AUTOLOAD: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == SSCD_IDLE && taken_q && snap_q[POS_AUTOLOAD] && !snap_q[POS_BACKUP] && card_present)
    |=> autoload_program_image_req && autoload_setup_image_req)
    else $error("autoload not started");
  AST_BACKUP_PRIO: assert property (@(posedge ref_clk) disable iff (rst)
    snap_q[POS_BACKUP] && taken_q |=> !autoload_program_image_req)
    else $error("autoload ran despite backup");
  AST_PERIPH: assert property (@(posedge ref_clk) disable iff (rst)
    taken_q |=> periph_use_stored_setup == $past(snap_q[POS_PERIPH_SETUP]))
    else $error("peripheral source wrong");
  AST_SERIAL: assert property (@(posedge ref_clk) disable iff (rst)
    taken_q |=> serial_use_stored_setup == !$past(snap_q[POS_SERIAL_DEFAULT]))
    else $error("serial source wrong");
  AST_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    taken_q |=> user_switch_flag_bit == $past(snap_q[POS_USER_FLAG]))
    else $error("user flag mismatch");
  AST_VERIFY: assert property (@(posedge ref_clk) disable iff (rst)
    taken_q |=> card_write_allow == $past(snap_q[POS_BACKUP]) && card_verify_mode != card_write_allow)
    else $error("card mode inconsistent");
  AST_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
    program_mode_lock |=> program_mode_lock && !mode_change_ok)
    else $error("lock released or mode changed");
  AST_SNAP: assert property (@(posedge ref_clk) disable iff (rst)
    taken_q |=> $stable(snap_q))
    else $error("snapshot moved");
  COV_RESTORE: cover property (@(posedge ref_clk) disable iff (rst) st_q == SSCD_RESTORE ##1 program_mode_lock);
  COV_AUTOLOAD: cover property (@(posedge ref_clk) disable iff (rst) autoload_program_image_req ##1 st_q == SSCD_RUN);
  COV_LOCKED: cover property (@(posedge ref_clk) disable iff (rst) periph_baud_locked);
endmodule : sscd_top
`default_nettype wire

// ==== verif/sscd_sw_model.sv ====
// Partner model: the operator switch and a memory card that answers requests.
// Assumes one clock and registered request levels from the decoder.
`default_nettype none
module sscd_sw_model
#(
  parameter int CARD_DELAY = 5
)
(
  input wire logic ref_clk,
  input wire logic [7:0] sw_set,
  input wire logic load_req,
  input wire logic restore_req,
  output logic [7:0] dip_sw,
  output logic load_done,
  output logic restore_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Position 8 is not used and always reads off, whatever the bench sets.
  assign dip_sw = {1'b0, sw_set[6:0]};
  // Card starts idle so the decoder sees no stray completion.
  initial
  begin
    cnt = 0;
    load_done = 1'b0;
    restore_done = 1'b0;
  end
  // Card answers with one pulse after a fixed delay; a longer CARD_DELAY only delays it.
  always @(posedge ref_clk)
  begin
    cnt <= (load_req || restore_req) ? cnt + 1 : 0;
    load_done <= load_req && cnt == CARD_DELAY;
    restore_done <= restore_req && cnt == CARD_DELAY;
  end
endmodule : sscd_sw_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the start-up switch decoder.
// Assumes the switch model file is compiled first.
`default_nettype none
module testbench
  import sscd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sw_set = 8'h00;
  logic card_present = 1'b0;
  logic wr_req = 1'b0;
  logic mode_req = 1'b0;
  logic detect = 1'b0;
  logic [7:0] dip_sw;
  logic load_done, restore_done, wr_en, prg_req, set_req, rs_req, wr_allow, verify;
  logic per_st, ser_st, flag, lock, mode_ok, locked;
  logic [1:0] baud;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int i;
  always #10 ref_clk = ~ref_clk;
  sscd_sw_model u_sw (.ref_clk(ref_clk), .sw_set(sw_set), .load_req(prg_req), .restore_req(rs_req),
    .dip_sw(dip_sw), .load_done(load_done), .restore_done(restore_done));
  sscd_top u_dut (.ref_clk(ref_clk), .rst(rst), .dip_sw(dip_sw), .card_present(card_present),
    .load_done(load_done), .restore_done(restore_done), .user_program_memory_wr_req(wr_req),
    .mode_change_req(mode_req), .periph_detect(detect), .user_program_memory_wr_en(wr_en),
    .autoload_program_image_req(prg_req), .autoload_setup_image_req(set_req), .restore_req(rs_req),
    .card_write_allow(wr_allow), .card_verify_mode(verify), .periph_use_stored_setup(per_st),
    .serial_use_stored_setup(ser_st), .user_switch_flag_bit(flag), .program_mode_lock(lock),
    .mode_change_ok(mode_ok), .periph_baud_sel(baud), .periph_baud_locked(locked));
  // ****************************************
  // Shared tasks
  // ****************************************
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reset for 8 cycles with the switch already set, then let the snapshot settle.
  task boot(input logic [7:0] sw, input logic card);
    @(posedge ref_clk);
    rst <= 1'b1;
    sw_set <= sw;
    card_present <= card;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : boot
  // One-cycle pulses on write and mode requests, answered on the next edge.
  task pulse_reqs(input logic exp_wr, input logic exp_mode);
    @(posedge ref_clk);
    wr_req <= 1'b1;
    mode_req <= 1'b1;
    @(posedge ref_clk);
    wr_req <= 1'b0;
    mode_req <= 1'b0;
    #1;
    chk(4'(wr_en), 4'(exp_wr));
    chk(4'(mode_ok), 4'(exp_mode));
    @(posedge ref_clk);
    #1;
    chk(4'({wr_en, mode_ok}), 4'h0);
  endtask : pulse_reqs
  // ****************************************
  // Scenarios
  // ****************************************
  task t_decode(input logic [7:0] sw);
    boot(sw, 1'b0);
    chk(4'(flag), 4'(sw[POS_USER_FLAG]));
    chk(4'(per_st), 4'(sw[POS_PERIPH_SETUP]));
    chk(4'(ser_st), 4'(!sw[POS_SERIAL_DEFAULT]));
    chk(4'({wr_allow, verify}), 4'({sw[POS_BACKUP], !sw[POS_BACKUP]}));
    chk(4'({prg_req, set_req, rs_req}), 4'h0);
    pulse_reqs(!sw[POS_WRITE_PROTECT], 1'b1);
    $display("test decode %h done", sw);
  endtask : t_decode
  task t_autoload;
    boot(8'h02, 1'b1);
    chk(4'({prg_req, set_req, rs_req}), 4'h6);
    for (i = 0; i < 30 && prg_req !== 1'b0; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk(4'({prg_req, set_req, lock}), 4'h0);
    $display("test autoload done");
  endtask : t_autoload
  task t_restore;
    boot(8'h42, 1'b1);
    chk(4'({prg_req, set_req, rs_req}), 4'h1);
    // Flip the switch after start-up: the decoder must keep its snapshot.
    @(posedge ref_clk);
    sw_set <= 8'h01;
    for (i = 0; i < 30 && rs_req !== 1'b0; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    repeat (2) @(posedge ref_clk);
    #1;
    chk(4'({prg_req, lock, wr_allow}), 4'h3);
    pulse_reqs(1'b1, 1'b0);
    $display("test restore done");
  endtask : t_restore
  task t_baud;
    boot(8'h00, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      for (i = 0; i < 1100 && baud !== 2'(c); i++)
      begin
        @(posedge ref_clk);
        #1;
      end
      chk(4'({locked, baud}), {2'h0, 2'(c)});
      // The first two full rates, 19200 and 38400, must each hold for exactly one dwell.
      if (c > 1)
      begin
        num_checks++;
        if (i != BAUD_DWELL_CYC)
        begin
          bad_count++;
          $display("wrong value at %0t got %h exp %h", $time, i, BAUD_DWELL_CYC);
        end
      end
    end
    @(posedge ref_clk);
    detect <= 1'b1;
    @(posedge ref_clk);
    detect <= 1'b0;
    repeat (1200) @(posedge ref_clk);
    #1;
    chk(4'({locked, baud}), {1'b0, 1'b1, BAUD_115200});
    $display("test baud done");
  endtask : t_baud
  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    t_decode(8'h00);
    t_decode(8'h79);
    t_autoload();
    t_restore();
    t_baud();
    summarize();
  end
endmodule : testbench
`default_nettype wire
